// ---- ntm_pkg.sv ----
// Constants and register map for the tape mark detector
package ntm_pkg;
	// Counter widths
	localparam int NTM_CNT_W = 4;
	// Spacing counter preset for nine-track units
	localparam logic [3:0] NTM_SPACE_PRESET = 4'h6;
	// Lowest spacing count that qualifies a second character
	localparam logic [3:0] NTM_SPACE_LO = 4'hc;
	// Highest spacing count, also the counter's ceiling
	localparam logic [3:0] NTM_SPACE_HI = 4'hf;
	// Gap count that declares the mark
	localparam logic [3:0] NTM_GAP_MARK = 4'h8;
	// Register byte offsets
	localparam logic [3:0] NTM_OFS_CTRL = 4'h0;
	localparam logic [3:0] NTM_OFS_STATE = 4'h4;
	localparam logic [3:0] NTM_OFS_INT_STAT = 4'h8;
	localparam logic [3:0] NTM_OFS_INT_MASK = 4'hc;
	// Control field: detector enable
	localparam int NTM_CTRL_EN_BIT = 0;
	localparam logic NTM_CTRL_RESET = 1'b1;
	// State register fields
	localparam int NTM_ST_WIN_BIT = 0;
	localparam int NTM_ST_FIRST_BIT = 1;
	localparam int NTM_ST_SECOND_BIT = 2;
	localparam int NTM_ST_MARK_BIT = 3;
	localparam int NTM_ST_GAPEN_BIT = 4;
	localparam int NTM_ST_SPACE_LSB = 8;
	localparam int NTM_ST_GAP_LSB = 12;
	// Interrupt event bits
	localparam int NTM_EV_W = 2;
	localparam int NTM_EV_MARK_BIT = 0;
	localparam int NTM_EV_REJECT_BIT = 1;
	localparam logic [1:0] NTM_EV_RESET = 2'h0;
	// AXI responses
	localparam logic [1:0] NTM_RESP_OKAY = 2'h0;
	localparam logic [1:0] NTM_RESP_SLVERR = 2'h2;
endpackage

// ---- ntm_sync_edge.sv ----
// Two-stage synchroniser with level and edge outputs
module ntm_sync_edge
	import ntm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	logic meta_q; // First stage, read only by the second
	logic sync_q; // Second stage
	logic prev_q; // Delayed copy for edge detection

	// Synchroniser chain and edge history
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Level and one-cycle rising pulse
	assign level_o = sync_q;
	assign rise_o = sync_q & ~prev_q;
endmodule

// ---- ntm_tick_counter.sv ----
// Presettable saturating up-counter advanced by a tick
module ntm_tick_counter
	import ntm_pkg::*;
#(
	parameter int W = NTM_CNT_W
)
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic tick_i,
	output logic [W-1:0] count_o,
	output logic full_o
);
	logic [W-1:0] count_q; // Current count
	logic [W-1:0] count_d; // Next count

	// Load wins over counting; holds at all ones
	assign full_o = &count_q;
	assign count_d = load_i ? load_val_i :
		(tick_i && !full_o) ? count_q + 1'b1 : count_q;
	assign count_o = count_q;

	// Count register
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			count_q <= '0;
		else
			count_q <= count_d;
	end
endmodule

// ---- ntm_mark_detector.sv ----
// Nine-track tape mark detector with AXI4-Lite registers
module ntm_mark_detector
	import ntm_pkg::*;
#(
	parameter logic [3:0] SPACE_PRESET = NTM_SPACE_PRESET
)
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Transport and timing inputs, asynchronous
	input wire logic char_strobe_i,
	input wire logic read_active_i,
	input wire logic write_timing_clock_i,
	input wire logic gap_count_clock_i,
	// Detector outputs
	output logic mark_detected_o,
	output logic gap_counter_enable_o,
	output logic irq_o,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Synchronised inputs
	logic strobe; // One pulse per character
	logic read_lvl; // Read active level
	logic read_rise; // Start of a read operation
	logic wtc_tick; // Write timing clock edge
	logic gap_tick; // Gap count clock edge

	// Detector state
	logic mark_window_q;
	logic first_short_q;
	logic second_short_q;
	logic mark_detected_q;
	logic space_late_q; // Spacing counter ran past its ceiling
	logic [3:0] space_cnt;
	logic space_full;
	logic [3:0] gap_cnt;

	// Registers
	logic ctrl_en_q; // Detector enable
	logic [NTM_EV_W-1:0] int_stat_q;
	logic [NTM_EV_W-1:0] int_mask_q;

	// Input synchronisers
	ntm_sync_edge u_strobe (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.async_i(char_strobe_i), .level_o(), .rise_o(strobe));
	ntm_sync_edge u_read (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.async_i(read_active_i), .level_o(read_lvl), .rise_o(read_rise));
	ntm_sync_edge u_wtc (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.async_i(write_timing_clock_i), .level_o(), .rise_o(wtc_tick));
	ntm_sync_edge u_gap (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.async_i(gap_count_clock_i), .level_o(), .rise_o(gap_tick));

	// Decodes of the character sequence
	wire active = read_lvl & ctrl_en_q; // Detector may run
	wire no_char_seen = ~first_short_q & ~second_short_q;
	wire first_char = active & strobe & no_char_seen;
	wire space_ok = (space_cnt >= NTM_SPACE_LO) & ~space_late_q;
	wire second_char = active & strobe & first_short_q;
	wire second_good = second_char & space_ok;
	wire extra_char = active & strobe & second_short_q;
	wire gap_en = mark_window_q & ~first_short_q & second_short_q;
	wire gap_eight = gap_en & (gap_cnt == NTM_GAP_MARK);
	wire reject = (second_char & ~space_ok) | (extra_char & mark_window_q);

	// Spacing counter, preset by the first character
	ntm_tick_counter #(.W(NTM_CNT_W)) u_space (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.load_i(~active | first_char),
		.load_val_i(SPACE_PRESET),
		.tick_i(first_short_q & wtc_tick),
		.count_o(space_cnt),
		.full_o(space_full)
	);

	// Gap counter, cleared by every character
	ntm_tick_counter #(.W(NTM_CNT_W)) u_gap_cnt (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.load_i(strobe | ~active),
		.load_val_i('0),
		.tick_i(gap_en & gap_tick & ~strobe),
		.count_o(gap_cnt),
		.full_o()
	);

	// Short-record stages and mark window
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i || !active)
		begin
			// Reinitialised during the start-motion delay
			first_short_q <= 1'b0;
			second_short_q <= 1'b0;
			mark_window_q <= 1'b0;
			space_late_q <= 1'b0;
		end
		else
		begin
			if (first_char)
			begin
				mark_window_q <= 1'b1;
				first_short_q <= 1'b1;
			end
			else if (second_char)
			begin
				// Window kept only for a well-spaced second character
				first_short_q <= 1'b0;
				second_short_q <= 1'b1;
				mark_window_q <= space_ok;
			end
			else if (extra_char)
				mark_window_q <= 1'b0; // A third character is a record
			// Counter pinned at its ceiling and ticked again: too late
			if (first_short_q && space_full && wtc_tick)
				space_late_q <= 1'b1;
		end
	end

	// Mark flag: set by gap count eight, cleared when a read begins
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			mark_detected_q <= 1'b0;
		else if (gap_eight)
			mark_detected_q <= 1'b1;
		else if (read_rise)
			mark_detected_q <= 1'b0;
	end

	assign mark_detected_o = mark_detected_q;
	assign gap_counter_enable_o = gap_en;

	// Bus handshake state
	logic aw_held_q; // Write address captured
	logic w_held_q; // Write data captured
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	// Write path decodes
	assign s_axi_awready = ~aw_held_q & ~bvalid_q;
	assign s_axi_wready = ~w_held_q & ~bvalid_q;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_held_q | aw_take;
	wire w_have = w_held_q | w_take;
	wire [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	wire wr_do = aw_have & w_have & ~bvalid_q;
	wire wr_lane0 = wr_do & wr_strb[0];
	wire wr_ctrl = wr_lane0 & (wr_addr == NTM_OFS_CTRL);
	wire wr_istat = wr_lane0 & (wr_addr == NTM_OFS_INT_STAT);
	wire wr_imask = wr_lane0 & (wr_addr == NTM_OFS_INT_MASK);
	wire wr_mapped = (wr_addr == NTM_OFS_CTRL) | (wr_addr == NTM_OFS_STATE)
		| (wr_addr == NTM_OFS_INT_STAT) | (wr_addr == NTM_OFS_INT_MASK);

	// Write channel capture and response
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= NTM_RESP_OKAY;
		end
		else
		begin
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_held_q <= wr_do ? 1'b0 : aw_have;
			w_held_q <= wr_do ? 1'b0 : w_have;
			if (wr_do)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? NTM_RESP_OKAY : NTM_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Event sources; a new event beats a same-cycle clear
	wire [NTM_EV_W-1:0] events = {reject, gap_eight & ~mark_detected_q};
	wire [NTM_EV_W-1:0] clr_mask = wr_istat ? wr_data[NTM_EV_W-1:0] : '0;

	// Control, mask and sticky status registers
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			ctrl_en_q <= NTM_CTRL_RESET;
			int_stat_q <= NTM_EV_RESET;
			int_mask_q <= NTM_EV_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_en_q <= wr_data[NTM_CTRL_EN_BIT];
			if (wr_imask)
				int_mask_q <= wr_data[NTM_EV_W-1:0];
			int_stat_q <= (int_stat_q & ~clr_mask) | events;
		end
	end

	assign irq_o = |(int_stat_q & int_mask_q);

	// Read data mux
	wire [31:0] state_word = {16'h0000, gap_cnt, space_cnt, 3'h0, gap_en,
		mark_detected_q, second_short_q, first_short_q, mark_window_q};
	wire rd_ctrl = s_axi_araddr == NTM_OFS_CTRL;
	wire rd_state = s_axi_araddr == NTM_OFS_STATE;
	wire rd_istat = s_axi_araddr == NTM_OFS_INT_STAT;
	wire rd_imask = s_axi_araddr == NTM_OFS_INT_MASK;
	wire rd_mapped = rd_ctrl | rd_state | rd_istat | rd_imask;
	wire [31:0] rd_word = rd_ctrl ? {31'h0, ctrl_en_q} :
		rd_state ? state_word :
		rd_istat ? {30'h0, int_stat_q} :
		rd_imask ? {30'h0, int_mask_q} : 32'h0;
	assign s_axi_arready = ~rvalid_q;
	wire ar_take = s_axi_arvalid & s_axi_arready;

	// Read channel
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= NTM_RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_mapped ? NTM_RESP_OKAY : NTM_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Checks on the detector sequence and the read channel
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	a_idle_clears_stages: assert property (
		!active |=> !first_short_q && !second_short_q)
		else $error("short stages not cleared while idle");
	a_first_opens_window: assert property (
		first_char |=> mark_window_q && first_short_q)
		else $error("first character did not open window");
	a_space_counts_up: assert property (
		first_short_q && wtc_tick && !space_full && !strobe && active
		|=> space_cnt == $past(space_cnt) + 4'h1)
		else $error("spacing counter did not advance");
	a_second_advances: assert property (
		second_good |=> mark_window_q && !first_short_q && second_short_q)
		else $error("good second character did not advance stages");
	a_gap_enable_cause: assert property (
		!gap_en |=> gap_cnt == 4'h0 || gap_cnt == $past(gap_cnt))
		else $error("gap counter moved while not enabled");
	a_eight_sets_mark: assert property (
		gap_en && gap_cnt == NTM_GAP_MARK |=> mark_detected_o)
		else $error("gap count eight did not set mark");
	a_space_preset: assert property (
		first_char |=> space_cnt == SPACE_PRESET)
		else $error("spacing counter not preset");
	a_strobe_clears_gap: assert property (
		strobe |=> gap_cnt == 4'h0)
		else $error("strobe did not clear gap counter");
	a_mark_holds: assert property (
		mark_detected_o && !read_rise |=> mark_detected_o)
		else $error("mark flag dropped before next read");
	a_bus_answers: assert property (
		ar_take |=> s_axi_rvalid)
		else $error("read not answered next cycle");
endmodule

// ---- ntm_transport_model.sv ----
// Behavioural transport: character strobes and timing clocks
module ntm_transport_model
(
	input wire logic clk_sys_i,
	output logic char_strobe_o,
	output logic write_timing_clock_o,
	output logic gap_count_clock_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// All three lines stand still low between pulses
	initial
	begin
		char_strobe_o = 1'b0;
		write_timing_clock_o = 1'b0;
		gap_count_clock_o = 1'b0;
	end
	// Give n pulses on one line, 3 clocks high and 3 low each
	task automatic pulse(input int sel, input int n);
		repeat (n)
		begin
			@(posedge clk_sys_i);
			if (sel == 0) char_strobe_o <= 1'b1;
			else if (sel == 1) write_timing_clock_o <= 1'b1;
			else gap_count_clock_o <= 1'b1;
			repeat (3) @(posedge clk_sys_i);
			char_strobe_o <= 1'b0;
			write_timing_clock_o <= 1'b0;
			gap_count_clock_o <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
		end
	endtask
endmodule

// ---- test_ntm_mark_detector.sv ----
// Self-checking bench for the tape mark detector
module test_ntm_mark_detector import ntm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic rd_act = 1'b0;
	logic strobe, wclk, gclk, mark, gap_en, irq;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int error_cnt = 0;
	int n_compared = 0;
	// Free-running system clock, 20 ns period
	always #10 clk_sys_i = ~clk_sys_i;
	ntm_transport_model i_model (.clk_sys_i(clk_sys_i),
		.char_strobe_o(strobe), .write_timing_clock_o(wclk),
		.gap_count_clock_o(gclk));
	ntm_mark_detector i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.char_strobe_i(strobe), .read_active_i(rd_act),
		.write_timing_clock_i(wclk), .gap_count_clock_i(gclk),
		.mark_detected_o(mark), .gap_counter_enable_o(gap_en),
		.irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// Compare one value and count it
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// AXI4-Lite write of one word, response must be OKAY
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		check(bresp, NTM_RESP_OKAY);
	endtask
	// AXI4-Lite read of one word into rv
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			if (arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rv = rdata;
		rready <= 1'b0;
		check(rresp, NTM_RESP_OKAY);
	endtask
	// Drop and raise read-active to start a new operation
	task automatic restart();
		@(posedge clk_sys_i);
		rd_act <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rd_act <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
	endtask
	// Two characters with n write-clock ticks between them
	task automatic send_pair(input int n);
		i_model.pulse(0, 1);
		i_model.pulse(1, n);
		i_model.pulse(0, 1);
		repeat (4) @(posedge clk_sys_i);
	endtask
	// Reset values of control and mask, read/write access of the mask
	task automatic t_regs();
		rd(NTM_OFS_CTRL);
		check(rv, 32'h1);
		rd(NTM_OFS_INT_MASK);
		check(rv, 32'h0);
		wr(NTM_OFS_INT_MASK, 32'h3);
		rd(NTM_OFS_INT_MASK);
		check(rv, 32'h3);
		wr(NTM_OFS_INT_MASK, 32'h0);
	endtask
	// Spacing of n ticks is accepted only for six to nine
	task automatic t_spacing(input int n);
		logic acc;
		acc = (n >= 6) && (n <= 9);
		restart();
		send_pair(n);
		rd(NTM_OFS_STATE);
		check(rv[4], acc);
		check(rv[0], acc);
		check(gap_en, acc);
		rd(NTM_OFS_INT_STAT);
		check(rv[1], !acc);
		wr(NTM_OFS_INT_STAT, 32'h3);
	endtask
	// Full mark, interrupt masking and hold of the flag
	task automatic t_mark();
		wr(NTM_OFS_INT_MASK, 32'h1);
		restart();
		send_pair(6);
		rd(NTM_OFS_STATE);
		check(rv[15:0], 32'h0c15);
		i_model.pulse(2, 7);
		repeat (4) @(posedge clk_sys_i);
		check(mark, 1'b0);
		i_model.pulse(2, 1);
		repeat (4) @(posedge clk_sys_i);
		check(mark, 1'b1);
		rd(NTM_OFS_STATE);
		check({rv[15:12], rv[3]}, 5'h11);
		check(irq, 1'b1);
		wr(NTM_OFS_INT_MASK, 32'h0);
		check(irq, 1'b0);
		wr(NTM_OFS_INT_MASK, 32'h1);
		wr(NTM_OFS_INT_STAT, 32'h1);
		check(irq, 1'b0);
		rd(NTM_OFS_INT_STAT);
		check(rv, 32'h0);
		@(posedge clk_sys_i);
		rd_act <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		check(mark, 1'b1);
		rd(NTM_OFS_STATE);
		check(rv[2:0], 3'h0);
		rd_act <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		check(mark, 1'b0);
		wr(NTM_OFS_INT_MASK, 32'h0);
	endtask
	// Gap ticks then a third character: record, not a mark
	task automatic t_third();
		restart();
		send_pair(7);
		i_model.pulse(2, 3);
		repeat (4) @(posedge clk_sys_i);
		rd(NTM_OFS_STATE);
		check(rv[15:12], 4'h3);
		i_model.pulse(0, 1);
		repeat (4) @(posedge clk_sys_i);
		rd(NTM_OFS_STATE);
		check(rv[15:12], 4'h0);
		check(rv[4:0], 5'h04);
		check(gap_en, 1'b0);
		rd(NTM_OFS_INT_STAT);
		check(rv, 32'h2);
		wr(NTM_OFS_INT_STAT, 32'h3);
	endtask
	// Strobes are ignored while the detector is disabled
	task automatic t_disable();
		wr(NTM_OFS_CTRL, 32'h0);
		restart();
		i_model.pulse(0, 1);
		rd(NTM_OFS_STATE);
		check(rv[1:0], 2'h0);
		wr(NTM_OFS_CTRL, 32'h1);
	endtask
	// Print the counts and the verdict, then stop
	task automatic close_out();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Cut a hang short well after the tests should end
	initial
	begin
		#200000;
		error_cnt++;
		close_out();
	end
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		t_regs();
		t_spacing(5);
		t_spacing(6);
		t_spacing(9);
		t_spacing(10);
		t_mark();
		t_third();
		t_disable();
		close_out();
	end
endmodule
